// ---- rtk_pkg.sv ----
`default_nettype none
package rtk_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL = 6'h00;
  localparam logic [5:0] IDX_CAL = 6'h01;
  localparam logic [5:0] IDX_SEC = 6'h02;
  localparam logic [5:0] IDX_MIN = 6'h03;
  localparam logic [5:0] IDX_HOUR = 6'h04;
  localparam logic [5:0] IDX_DOW = 6'h05;
  localparam logic [5:0] IDX_DATE = 6'h06;
  localparam logic [5:0] IDX_MONTH = 6'h07;
  localparam logic [5:0] IDX_YEAR = 6'h08;
  localparam logic [5:0] IDX_CHG = 6'h0B;

  // Control register fields
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_CAL_BIT = 2;
  // Calibration register fields
  localparam int CAL_MAG_W = 5;
  localparam int CAL_SIGN_BIT = 5;
  // Charger register fields
  localparam int CHG_ENABLE_BIT = 2;
  localparam int CHG_FAST_BIT = 5;

  // Time limits
  localparam logic [7:0] SEC_LAST = 8'h3B;
  localparam logic [7:0] MIN_LAST = 8'h3B;
  localparam logic [7:0] HOUR_LAST = 8'h17;
  localparam logic [7:0] DOW_LAST = 8'h07;
  localparam logic [7:0] MONTH_LAST = 8'h0C;
  localparam logic [7:0] YEAR_LAST = 8'h63;
  localparam logic [7:0] DAYS_31 = 8'h1F;
  localparam logic [7:0] DAYS_30 = 8'h1E;
  localparam logic [7:0] DAYS_29 = 8'h1D;
  localparam logic [7:0] DAYS_28 = 8'h1C;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h0B;
  localparam logic [7:0] FIRST_ONE = 8'h01;
  localparam logic [7:0] FIRST_ZERO = 8'h00;

  // Time base and divider
  localparam real TIMEBASE_HZ = 32768.0;
  localparam int TIMEBASE_DIV = 32768;
  localparam int SQ_WAVE_BIT = 5;
  localparam int CAL_PERIOD_S = 8;
  localparam logic [CAL_MAG_W-1:0] CAL_RESET = 5'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtk_time_s;

  localparam rtk_time_s TIME_RESET = '{sec: 8'h00, min: 8'h00, hour: 8'h00, dow: 8'h01,
                                       date: 8'h01, month: 8'h01, year: 8'h00};

endpackage
`default_nettype wire

// ---- rtk_tick_next.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtk_tick_next
  import rtk_pkg::*;
(
  // Present time
  input wire rtk_time_s cur,
  // Time one second later
  output rtk_time_s nxt
);

  logic [7:0] days_in_month;

  always_comb begin
    case (cur.month)
      MONTH_FEB: days_in_month = (cur.year[1:0] == 2'b00) ? DAYS_29 : DAYS_28;
      MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: days_in_month = DAYS_30;
      default: days_in_month = DAYS_31;
    endcase
  end

  // Out-of-range values wrap at the next carry instead of counting on
  always_comb begin
    nxt = cur;
    if (cur.sec < SEC_LAST) begin
      nxt.sec = cur.sec + FIRST_ONE;
    end else begin
      nxt.sec = FIRST_ZERO;
      if (cur.min < MIN_LAST) begin
        nxt.min = cur.min + FIRST_ONE;
      end else begin
        nxt.min = FIRST_ZERO;
        if (cur.hour < HOUR_LAST) begin
          nxt.hour = cur.hour + FIRST_ONE;
        end else begin
          nxt.hour = FIRST_ZERO;
          nxt.dow = (cur.dow < DOW_LAST) ? cur.dow + FIRST_ONE : FIRST_ONE;
          if (cur.date < days_in_month) begin
            nxt.date = cur.date + FIRST_ONE;
          end else begin
            nxt.date = FIRST_ONE;
            if (cur.month < MONTH_LAST) begin
              nxt.month = cur.month + FIRST_ONE;
            end else begin
              nxt.month = FIRST_ONE;
              nxt.year = (cur.year < YEAR_LAST) ? cur.year + FIRST_ONE : FIRST_ZERO;
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtk_timekeeper.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Rising read-snapshot bit copies core time into holding registers.
// - A pending core tick completes before the snapshot is loaded.
// - Holding registers stay frozen while the read-snapshot bit is one; here host time writes still reach them if the write-lock bit is also set.
// - Write-lock bit set: host writes collect in holding registers only.
// - Write-lock bit cleared: holding registers load the core as new time.
// - Core always advances; holding registers track it unless read-snapshot or write-lock bit is set.
// - Divide the 32.768 kHz time base down to one-second ticks.
// - Readable, writable seconds, minutes, hours, weekday, date, month, year.
// - Calibration bit set: shared pin leaves power-fail duty for calibration.
// - In calibration mode the shared pin carries a 512 Hz square wave.
// - Correction removes divider pulses for fast clock, adds for slow.
// - Correction sign one adds pulses, zero removes pulses.
// - Five-bit correction magnitude at calibration register bits four to zero.
// - Correction writes take effect only while calibration bit is one.
// - Clearing calibration bit returns shared pin to power-fail output.
// - Charge register bit two switches trickle charger on or off.
// - Charge register bit five selects the fast charge current.
// - Calibration code is sign bit above five-bit step count.
module rtk_timekeeper
  import rtk_pkg::*;
#(
  parameter int DIV_COUNT = TIMEBASE_DIV,
  parameter int CAL_PERIOD = CAL_PERIOD_S,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic timebase_in,
  input wire logic powerfail_n_in,
  output logic cal_or_powerfail_pin_q,
  output logic backup_charge_enable_q,
  output logic fast_charge_select_q
);

  localparam int DIV_W = $clog2(DIV_COUNT) + 2;
  localparam int PER_W = $clog2(CAL_PERIOD) + 1;
  localparam logic [DIV_W-1:0] DIV_LIMIT = DIV_W'(DIV_COUNT);
  localparam logic [PER_W-1:0] PER_LAST = PER_W'(CAL_PERIOD - 1);

  // Pin synchronisers
  logic tb_meta_q, tb_sync_q, tb_prev_q;
  logic pf_meta_q, pf_sync_q;
  logic tb_tick;

  // Kept running through reset so a high time base gives no false edge at release
  always_ff @(posedge aclk) begin
    tb_meta_q <= timebase_in;
    tb_sync_q <= tb_meta_q;
    tb_prev_q <= tb_sync_q;
    pf_meta_q <= powerfail_n_in;
    pf_sync_q <= pf_meta_q;
  end

  assign tb_tick = tb_sync_q & ~tb_prev_q;

  // Register state
  logic read_snap_q, write_lock_q, cal_mode_q;
  logic cal_sign_q;
  logic [CAL_MAG_W-1:0] cal_mag_q;
  rtk_time_s core_q, hold_q, core_d, core_next;

  // AXI write path
  logic aw_pend_q, w_pend_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic do_write;
  logic [5:0] wr_idx;
  logic wr_ok;

  assign do_write = aw_pend_q & w_pend_q & ~s_axi_bvalid;
  assign wr_idx = aw_addr_q[ADDR_W-1:2];

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx <= IDX_YEAR) || (idx == IDX_CHG);
  endfunction

  assign wr_ok = do_write & w_lane_q & idx_mapped(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_pend_q <= 1'b0;
      w_pend_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_pend_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_pend_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_pend_q <= 1'b0;
        w_pend_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      // Ready returns only after the response, so one write at a time
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control bit edges seen on the write that changes them
  logic wr_ctl, snap_rise, lock_fall, wr_time;

  assign wr_ctl = wr_ok && (wr_idx == IDX_CTL);
  assign snap_rise = wr_ctl && w_byte_q[CTL_READ_BIT] && !read_snap_q;
  assign lock_fall = wr_ctl && !w_byte_q[CTL_WRITE_BIT] && write_lock_q;
  assign wr_time = wr_ok && (wr_idx >= IDX_SEC) && (wr_idx <= IDX_YEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_snap_q <= 1'b0;
      write_lock_q <= 1'b0;
      cal_mode_q <= 1'b0;
    end else if (wr_ctl) begin
      read_snap_q <= w_byte_q[CTL_READ_BIT];
      write_lock_q <= w_byte_q[CTL_WRITE_BIT];
      cal_mode_q <= w_byte_q[CTL_CAL_BIT];
    end
  end

  // No backing store here: reset stands in for the retained correction value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_mag_q <= CAL_RESET;
      cal_sign_q <= 1'b0;
    end else if (wr_ok && (wr_idx == IDX_CAL) && cal_mode_q) begin
      cal_mag_q <= w_byte_q[CAL_MAG_W-1:0];
      cal_sign_q <= w_byte_q[CAL_SIGN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_charge_enable_q <= 1'b0;
      fast_charge_select_q <= 1'b0;
    end else if (wr_ok && (wr_idx == IDX_CHG)) begin
      backup_charge_enable_q <= w_byte_q[CHG_ENABLE_BIT];
      fast_charge_select_q <= w_byte_q[CHG_FAST_BIT];
    end
  end

  // Divider with pulse add/remove correction
  logic [DIV_W-1:0] div_q, div_sum;
  logic [1:0] div_inc;
  logic [CAL_MAG_W-1:0] corr_left_q;
  logic [PER_W-1:0] per_q;
  logic sec_tick;

  always_comb begin
    div_inc = 2'h1;
    if (corr_left_q != '0) begin
      div_inc = cal_sign_q ? 2'h2 : 2'h0;
    end
  end

  assign div_sum = div_q + {{(DIV_W-2){1'b0}}, div_inc};
  assign sec_tick = tb_tick && (div_sum >= DIV_LIMIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else if (tb_tick) begin
      div_q <= sec_tick ? div_sum - DIV_LIMIT : div_sum;
    end
  end

  // Correction loaded once per period, then applied on consecutive time-base ticks until used up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_q <= '0;
      corr_left_q <= '0;
    end else begin
      if (sec_tick) begin
        per_q <= (per_q == PER_LAST) ? '0 : per_q + 1'b1;
      end
      if (sec_tick && per_q == PER_LAST) begin
        corr_left_q <= cal_mag_q;
      end else if (tb_tick && corr_left_q != '0) begin
        corr_left_q <= corr_left_q - 1'b1;
      end
    end
  end

  rtk_tick_next u_tick_next (
    .cur(core_q),
    .nxt(core_next)
  );

  assign core_d = sec_tick ? core_next : core_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_q <= TIME_RESET;
    end else if (lock_fall) begin
      core_q <= hold_q;
    end else begin
      core_q <= core_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= TIME_RESET;
    end else if (snap_rise) begin
      hold_q <= core_d;
    end else if (write_lock_q && wr_time) begin
      case (wr_idx)
        IDX_SEC: hold_q.sec <= w_byte_q;
        IDX_MIN: hold_q.min <= w_byte_q;
        IDX_HOUR: hold_q.hour <= w_byte_q;
        IDX_DOW: hold_q.dow <= w_byte_q;
        IDX_DATE: hold_q.date <= w_byte_q;
        IDX_MONTH: hold_q.month <= w_byte_q;
        default: hold_q.year <= w_byte_q;
      endcase
    end else if (!read_snap_q && !write_lock_q) begin
      hold_q <= core_d;
    end
  end

  // Shared pin: square wave from divider, else comparator level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_or_powerfail_pin_q <= 1'b1;
    end else if (cal_mode_q) begin
      cal_or_powerfail_pin_q <= div_q[SQ_WAVE_BIT];
    end else begin
      cal_or_powerfail_pin_q <= pf_sync_q;
    end
  end

  // AXI read path
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_CTL: begin
        rd_byte[CTL_READ_BIT] = read_snap_q;
        rd_byte[CTL_WRITE_BIT] = write_lock_q;
        rd_byte[CTL_CAL_BIT] = cal_mode_q;
      end
      IDX_CAL: begin
        rd_byte[CAL_MAG_W-1:0] = cal_mag_q;
        rd_byte[CAL_SIGN_BIT] = cal_sign_q;
      end
      IDX_SEC: rd_byte = hold_q.sec;
      IDX_MIN: rd_byte = hold_q.min;
      IDX_HOUR: rd_byte = hold_q.hour;
      IDX_DOW: rd_byte = hold_q.dow;
      IDX_DATE: rd_byte = hold_q.date;
      IDX_MONTH: rd_byte = hold_q.month;
      IDX_YEAR: rd_byte = hold_q.year;
      IDX_CHG: begin
        rd_byte[CHG_ENABLE_BIT] = backup_charge_enable_q;
        rd_byte[CHG_FAST_BIT] = fast_charge_select_q;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- rtk_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtk_props
  import rtk_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Charger outputs
  input wire logic backup_charge_enable_q,
  input wire logic fast_charge_select_q
);
  logic wr_take;
  logic ar_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    wr_take;
  endsequence
  // Readies drop first, response one cycle later
  sequence s_wr_answer;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write response not on time");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_charge_on: assert property (wr_take && s_axi_wstrb[0] && s_axi_awaddr[7:2] == IDX_CHG
    |=> ##1 backup_charge_enable_q == $past(s_axi_wdata[CHG_ENABLE_BIT], 2)) else $error("charger enable wrong");
  chk_fast_select: assert property (wr_take && s_axi_wstrb[0] && s_axi_awaddr[7:2] == IDX_CHG
    |=> ##1 fast_charge_select_q == $past(s_axi_wdata[CHG_FAST_BIT], 2)) else $error("fast charge wrong");
  chk_unmapped_wr: assert property (wr_take && s_axi_awaddr[7:2] == 6'h09
    |=> ##1 s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  chk_unmapped_rd: assert property (ar_take && s_axi_araddr[7:2] == 6'h0A
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
endmodule
bind rtk_timekeeper rtk_props #(.ADDR_W(ADDR_W)) i_props (.*);
`default_nettype wire

// ---- rtk_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module rtk_host
  import rtk_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Each channel released only at the edge that takes it
  task automatic wr(input logic [5:0] idx, input logic [7:0] val, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= ADDR_W'({idx, 2'b00});
    s_axi_wdata <= {24'h00_0000, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= ADDR_W'({idx, 2'b00});
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (a), (b)); end end
module testbench;
  import rtk_pkg::*;
  localparam int DIVN = 64;
  localparam int SEC_CYC = DIVN * 8;
  localparam logic [7:0] TV [7] = '{8'h3B, 8'h3B, 8'h17, 8'h07, 8'h1F, 8'h0C, 8'h63};
  localparam logic [7:0] CV [4] = '{8'h04, 8'h20, 8'h24, 8'h00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic timebase_in = 1'b0;
  logic powerfail_n_in = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, tb_cnt = 2'h0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cal_or_powerfail_pin_q, backup_charge_enable_q, fast_charge_select_q;
  int cyc = 0;
  int err_total = 0;
  int total_checks = 0;
  always #5 aclk = ~aclk;
  // Time base at one eighth of the bus clock
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    tb_cnt <= tb_cnt + 2'h1;
    if (tb_cnt == 2'h3) timebase_in <= ~timebase_in;
  end
  rtk_timekeeper #(.DIV_COUNT(DIVN), .CAL_PERIOD(2)) i_dut (.*);
  rtk_host #(.ADDR_W(8)) i_host (.*);
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    i_host.rd(idx, rdat, resp);
    `CHK(rdat, {24'h00_0000, exp})
  endtask
  // Polls seconds until it moves, so later steps start just after a tick
  task automatic wait_tick;
    logic [7:0] s0;
    i_host.rd(IDX_SEC, rdat, resp);
    s0 = rdat[7:0];
    for (int i = 0; i < 1000 && rdat[7:0] === s0; i++) i_host.rd(IDX_SEC, rdat, resp);
  endtask
  task automatic t_reset;
    for (int k = 0; k < 7; k++) rd_chk(IDX_SEC + 6'(k), TIME_RESET[55 - 8 * k -: 8]);
    `CHK(backup_charge_enable_q, 1'b0)
    `CHK(cal_or_powerfail_pin_q, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_lock_hold;
    i_host.wr(IDX_CTL, 8'h02, resp);
    i_host.wr(IDX_SEC, 8'h10, resp);
    rd_chk(IDX_SEC, 8'h10);
    repeat (SEC_CYC + 100) @(posedge aclk);
    rd_chk(IDX_SEC, 8'h10);
    i_host.wr(IDX_CTL, 8'h00, resp);
    $display("test lock hold done");
  endtask
  task automatic t_rollover;
    wait_tick;
    i_host.wr(IDX_CTL, 8'h02, resp);
    for (int k = 0; k < 7; k++) i_host.wr(IDX_SEC + 6'(k), TV[k], resp);
    i_host.wr(IDX_CTL, 8'h00, resp);
    i_host.wr(IDX_CTL, 8'h01, resp);
    for (int k = 0; k < 7; k++) rd_chk(IDX_SEC + 6'(k), TV[k]);
    repeat (SEC_CYC) @(posedge aclk);
    rd_chk(IDX_SEC, TV[0]);
    i_host.wr(IDX_CTL, 8'h00, resp);
    i_host.wr(IDX_CTL, 8'h01, resp);
    for (int k = 0; k < 7; k++) rd_chk(IDX_SEC + 6'(k), TIME_RESET[55 - 8 * k -: 8]);
    i_host.wr(IDX_CTL, 8'h00, resp);
    $display("test rollover done");
  endtask
  task automatic t_second;
    int t0;
    wait_tick;
    t0 = cyc;
    wait_tick;
    `CHK((cyc - t0) inside {[SEC_CYC - 6 : SEC_CYC + 6]}, 1'b1)
    $display("test second done");
  endtask
  task automatic t_cal;
    int t0;
    int hi;
    int ex;
    i_host.wr(IDX_CAL, 8'h21, resp);
    rd_chk(IDX_CAL, 8'h00);
    i_host.wr(IDX_CTL, 8'h04, resp);
    powerfail_n_in <= 1'b0;
    for (int i = 0; i < 1000 && cal_or_powerfail_pin_q !== 1'b0; i++) @(posedge aclk);
    for (int i = 0; i < 1000 && cal_or_powerfail_pin_q !== 1'b1; i++) @(posedge aclk);
    hi = 0;
    while (hi < 1000 && cal_or_powerfail_pin_q === 1'b1) begin
      @(posedge aclk);
      hi++;
    end
    ex = (1 << SQ_WAVE_BIT) * 8;
    `CHK(hi inside {[ex - 4 : ex + 4]}, 1'b1)
    for (int s = 0; s < 2; s++) begin
      i_host.wr(IDX_CAL, 8'h1F | 8'(s << CAL_SIGN_BIT), resp);
      rd_chk(IDX_CAL, 8'h1F | 8'(s << CAL_SIGN_BIT));
      wait_tick;
      t0 = cyc;
      repeat (4) wait_tick;
      // Two correction windows of 31 steps fall in four seconds
      ex = (4 * DIVN - (2 * s - 1) * 62) * 8;
      `CHK((cyc - t0) inside {[ex - 24 : ex + 24]}, 1'b1)
    end
    i_host.wr(IDX_CTL, 8'h00, resp);
    repeat (8) @(posedge aclk);
    `CHK(cal_or_powerfail_pin_q, 1'b0)
    powerfail_n_in <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(cal_or_powerfail_pin_q, 1'b1)
    $display("test calibration done");
  endtask
  task automatic t_charge;
    for (int k = 0; k < 4; k++) begin
      i_host.wr(IDX_CHG, CV[k], resp);
      `CHK({fast_charge_select_q, backup_charge_enable_q}, {CV[k][CHG_FAST_BIT], CV[k][CHG_ENABLE_BIT]})
    end
    i_host.wr(6'h09, 8'h01, resp);
    `CHK(resp, RESP_SLVERR)
    i_host.rd(6'h0A, rdat, resp);
    `CHK(resp, RESP_SLVERR)
    $display("test charge done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_lock_hold;
    t_rollover;
    t_second;
    t_cal;
    t_charge;
    print_verdict;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
